/* File: design/rps_pkg.sv */
package rps_pkg;
    // Register byte addresses on the AXI4-Lite bus
    localparam logic [3:0] RPS_OFS_PAIR_A   = 4'h0;
    localparam logic [3:0] RPS_OFS_PAIR_B   = 4'h4;
    localparam int         RPS_ADDR_W       = 4;
    // Selector field layout inside each 16-bit register
    localparam int         RPS_SEL_W        = 6;
    localparam int         RPS_LO_LSB       = 0;
    localparam int         RPS_HI_LSB       = 8;
    localparam int         RPS_NUM_PINS     = 4;
    // Reset value of each selector: no peripheral connected
    localparam logic [5:0] RPS_SEL_NONE     = 6'h00;
    // Bits that hold selectors, unimplemented bits read as zero
    localparam logic [15:0] RPS_REG_MASK    = 16'h3f3f;
    // AXI responses
    localparam logic [1:0] RPS_RESP_OKAY    = 2'h0;
    localparam logic [1:0] RPS_RESP_SLVERR  = 2'h2;
endpackage

/* File: design/rps_sel_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Selector fields carried from the register file to the pin crossbar
interface rps_sel_if;
    logic [5:0] sel [4];   // One function number per remappable pin
    modport src (output sel);
    modport dst (input sel);
endinterface
`default_nettype wire

/* File: design/rps_xbar.sv */
`timescale 1ns/1ps
`default_nettype none
// Per-pin multiplexer: function number picks one peripheral output
module rps_xbar
    import rps_pkg::*;
#(
    parameter int NUM_FUNC = 64    // Peripheral outputs offered to the mux
) (
    rps_sel_if.dst                 sel_if,
    input  wire logic [NUM_FUNC-1:0] periph_out_i,
    output logic [3:0]             pin_data_d_o,
    output logic [3:0]             pin_remap_d_o
);
    genvar g;
    generate
        for (g = 0; g < RPS_NUM_PINS; g++) begin : g_pin
            // Zero selects no peripheral; port logic keeps the pin
            always_comb begin
                pin_remap_d_o[g] = (sel_if.sel[g] != RPS_SEL_NONE);   // [RULE6]
                if (int'(sel_if.sel[g]) < NUM_FUNC && pin_remap_d_o[g]) begin
                    pin_data_d_o[g] = periph_out_i[sel_if.sel[g]];    // [RULE1] [RULE2] [RULE3] [RULE4]
                end else begin
                    pin_data_d_o[g] = 1'b0;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* File: design/rps_top.sv */
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE1] Pair A bits 5-0 select pin one
// [RULE2] Pair A bits 13-8 select pin two
// [RULE3] Pair B bits 5-0 select pin three
// [RULE4] Pair B bits 13-8 select pin four
// [RULE5] Bits 15-14, 7-6 read zero, ignore writes
// [RULE6] Zero selector leaves pin to port
module rps_top
    import rps_pkg::*;
#(
    parameter int NUM_FUNC = 64            // Peripheral outputs available
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // AXI4-Lite slave
    input  wire logic [RPS_ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                  s_axi_awvalid_i,
    output logic                       s_axi_awready_o,
    input  wire logic [31:0]           s_axi_wdata_i,
    input  wire logic [3:0]            s_axi_wstrb_i,
    input  wire logic                  s_axi_wvalid_i,
    output logic                       s_axi_wready_o,
    output logic [1:0]                 s_axi_bresp_o,
    output logic                       s_axi_bvalid_o,
    input  wire logic                  s_axi_bready_i,
    input  wire logic [RPS_ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                  s_axi_arvalid_i,
    output logic                       s_axi_arready_o,
    output logic [31:0]                s_axi_rdata_o,
    output logic [1:0]                 s_axi_rresp_o,
    output logic                       s_axi_rvalid_o,
    input  wire logic                  s_axi_rready_i,
    // Peripheral side, same clock
    input  wire logic [NUM_FUNC-1:0]   periph_out_i,
    // Pin side
    output logic [3:0]                 pin_data_o,     // Remapped pin levels
    output logic [3:0]                 pin_remap_o     // High: peripheral owns pin
);
    rps_sel_if sel_bus ();

    // Register state
    logic [15:0] pair_a_q, pair_a_d;       // output_select_pair_a
    logic [15:0] pair_b_q, pair_b_d;       // output_select_pair_b
    // Write channel capture, address and data may come in either order
    logic                  aw_have_q, aw_have_d;
    logic                  w_have_q, w_have_d;
    logic [RPS_ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic [31:0]           w_data_q, w_data_d;
    logic [3:0]            w_strb_q, w_strb_d;
    logic                  bvalid_q, bvalid_d;
    logic [1:0]            bresp_q, bresp_d;
    // Read channel
    logic                  rvalid_q, rvalid_d;
    logic [31:0]           rdata_q, rdata_d;
    logic [1:0]            rresp_q, rresp_d;
    // Registered pin outputs
    logic [3:0]            pin_data_q, pin_remap_q;
    logic [3:0]            pin_data_d, pin_remap_d;
    // Ready flags registered so every bus output leaves a flop
    logic                  awready_q, awready_d;
    logic                  wready_q, wready_d;
    logic                  arready_q, arready_d;

    logic aw_take, w_take, ar_take, wr_fire;

    // Ready only while the slot is empty and no response is pending;
    // worked out one cycle ahead so the pins come straight from flops
    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o  = wready_q;
    assign s_axi_arready_o = arready_q;
    assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
    assign w_take  = s_axi_wvalid_i && s_axi_wready_o;
    assign ar_take = s_axi_arvalid_i && s_axi_arready_o;
    assign wr_fire = aw_have_q && w_have_q;

    // Write path next state
    always_comb begin
        logic [15:0] wd;
        wd        = w_data_q[15:0];
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        aw_addr_d = aw_addr_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        pair_a_d  = pair_a_q;
        pair_b_d  = pair_b_q;
        if (aw_take) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr_i;
        end
        if (w_take) begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata_i;
            w_strb_d = s_axi_wstrb_i;
        end
        if (wr_fire) begin
            // Both halves held: commit, masking unimplemented bits
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RPS_RESP_OKAY;
            unique case (aw_addr_q)
                RPS_OFS_PAIR_A: begin
                    if (w_strb_q[0]) pair_a_d[7:0]  = wd[7:0] & RPS_REG_MASK[7:0];   // [RULE5]
                    if (w_strb_q[1]) pair_a_d[15:8] = wd[15:8] & RPS_REG_MASK[15:8]; // [RULE5]
                end
                RPS_OFS_PAIR_B: begin
                    if (w_strb_q[0]) pair_b_d[7:0]  = wd[7:0] & RPS_REG_MASK[7:0];   // [RULE5]
                    if (w_strb_q[1]) pair_b_d[15:8] = wd[15:8] & RPS_REG_MASK[15:8]; // [RULE5]
                end
                // Unmapped address answers with an error, stores nothing
                default: bresp_d = RPS_RESP_SLVERR;
            endcase
        end else if (bvalid_q && s_axi_bready_i) begin
            bvalid_d = 1'b0;
        end
        // Next-cycle readiness follows the next slot and response state
        awready_d = !aw_have_d && !bvalid_d;
        wready_d  = !w_have_d && !bvalid_d;
    end

    // Read path next state; answer one cycle after the address is taken
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (ar_take) begin
            rvalid_d = 1'b1;
            rresp_d  = RPS_RESP_OKAY;
            unique case (s_axi_araddr_i)
                RPS_OFS_PAIR_A: rdata_d = {16'h0000, pair_a_q & RPS_REG_MASK}; // [RULE5]
                RPS_OFS_PAIR_B: rdata_d = {16'h0000, pair_b_q & RPS_REG_MASK}; // [RULE5]
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = RPS_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready_i) begin
            rvalid_d = 1'b0;
        end
        // No new address while a read answer is still pending
        arready_d = !rvalid_d;
    end

    // Selector fields to the crossbar
    assign sel_bus.sel[0] = pair_a_q[RPS_LO_LSB +: RPS_SEL_W];   // [RULE1]
    assign sel_bus.sel[1] = pair_a_q[RPS_HI_LSB +: RPS_SEL_W];   // [RULE2]
    assign sel_bus.sel[2] = pair_b_q[RPS_LO_LSB +: RPS_SEL_W];   // [RULE3]
    assign sel_bus.sel[3] = pair_b_q[RPS_HI_LSB +: RPS_SEL_W];   // [RULE4]

    rps_xbar #(
        .NUM_FUNC (NUM_FUNC)
    ) u_xbar (
        .sel_if        (sel_bus.dst),
        .periph_out_i  (periph_out_i),
        .pin_data_d_o  (pin_data_d),
        .pin_remap_d_o (pin_remap_d)
    );

    // All state registered; pins register the mux so outputs come from flops,
    // at the cost of one cycle of added latency on peripheral signals
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pair_a_q    <= 16'h0000;
            pair_b_q    <= 16'h0000;
            aw_have_q   <= 1'b0;
            w_have_q    <= 1'b0;
            aw_addr_q   <= '0;
            w_data_q    <= 32'h0000_0000;
            w_strb_q    <= 4'h0;
            bvalid_q    <= 1'b0;
            bresp_q     <= RPS_RESP_OKAY;
            rvalid_q    <= 1'b0;
            rdata_q     <= 32'h0000_0000;
            rresp_q     <= RPS_RESP_OKAY;
            pin_data_q  <= 4'h0;
            pin_remap_q <= 4'h0;
            awready_q   <= 1'b1;
            wready_q    <= 1'b1;
            arready_q   <= 1'b1;
        end else begin
            pair_a_q    <= pair_a_d;
            pair_b_q    <= pair_b_d;
            aw_have_q   <= aw_have_d;
            w_have_q    <= w_have_d;
            aw_addr_q   <= aw_addr_d;
            w_data_q    <= w_data_d;
            w_strb_q    <= w_strb_d;
            bvalid_q    <= bvalid_d;
            bresp_q     <= bresp_d;
            rvalid_q    <= rvalid_d;
            rdata_q     <= rdata_d;
            rresp_q     <= rresp_d;
            pin_data_q  <= pin_data_d;
            pin_remap_q <= pin_remap_d;
            awready_q   <= awready_d;
            wready_q    <= wready_d;
            arready_q   <= arready_d;
        end
    end

    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o  = bresp_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o  = rdata_q;
    assign s_axi_rresp_o  = rresp_q;
    assign pin_data_o     = pin_data_q;
    assign pin_remap_o    = pin_remap_q;

    // Checks
    a_pin_one_route: assert property (@(posedge clk_i) disable iff (rst_i)   // [RULE1]
        (pair_a_q[5:0] != 6'h00 && int'(pair_a_q[5:0]) < NUM_FUNC)
        |=> pin_remap_o[0] && pin_data_o[0] == $past(periph_out_i[pair_a_q[5:0]]))
        else $error("pin one not driven by selected function");
    a_pin_two_route: assert property (@(posedge clk_i) disable iff (rst_i)   // [RULE2]
        (pair_a_q[13:8] != 6'h00 && int'(pair_a_q[13:8]) < NUM_FUNC)
        |=> pin_remap_o[1] && pin_data_o[1] == $past(periph_out_i[pair_a_q[13:8]]))
        else $error("pin two not driven by selected function");
    a_pin_three_route: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
        (pair_b_q[5:0] != 6'h00 && int'(pair_b_q[5:0]) < NUM_FUNC)
        |=> pin_remap_o[2] && pin_data_o[2] == $past(periph_out_i[pair_b_q[5:0]]))
        else $error("pin three not driven by selected function");
    a_pin_four_route: assert property (@(posedge clk_i) disable iff (rst_i)  // [RULE4]
        (pair_b_q[13:8] != 6'h00 && int'(pair_b_q[13:8]) < NUM_FUNC)
        |=> pin_remap_o[3] && pin_data_o[3] == $past(periph_out_i[pair_b_q[13:8]]))
        else $error("pin four not driven by selected function");
    a_unimpl_read_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
        ar_take |=> (s_axi_rdata_o & ~{16'h0000, RPS_REG_MASK}) == 32'h0000_0000)
        else $error("unimplemented bits read nonzero");
    a_unimpl_store_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
        ((pair_a_q | pair_b_q) & ~RPS_REG_MASK) == 16'h0000)
        else $error("unimplemented bits stored");
    a_zero_sel_port: assert property (@(posedge clk_i) disable iff (rst_i)   // [RULE6]
        (pair_a_q[5:0] == 6'h00) |=> !pin_remap_o[0] && !pin_data_o[0])
        else $error("pin one taken with zero selector");
    a_write_resp_time: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_fire |=> s_axi_bvalid_o && !s_axi_awready_o && !s_axi_wready_o)
        else $error("write response missing");
    c_write_a: cover property (@(posedge clk_i) wr_fire && aw_addr_q == RPS_OFS_PAIR_A);
    c_write_b: cover property (@(posedge clk_i) wr_fire && aw_addr_q == RPS_OFS_PAIR_B);
    c_read_ok: cover property (@(posedge clk_i) s_axi_rvalid_o && s_axi_rresp_o == RPS_RESP_OKAY);
    c_all_remap: cover property (@(posedge clk_i) pin_remap_o == 4'hf);
endmodule
`default_nettype wire

/* File: tb/rps_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: AXI4-Lite register access and pin routing
module tb
    import rps_pkg::*;
;
    logic        clk_i = 1'b0;      // 100 MHz system clock
    logic        rst_i = 1'b1;      // Async reset, active high
    logic [3:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic        bready = 1'b1, rready = 1'b1;  // Held high: never stalls answers
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [63:0] periph = '0;       // Peripheral output levels
    logic [3:0]  pin_data, pin_remap;
    logic [5:0]  sel_m [4] = '{default: 6'h00};  // Expected selectors
    int          err_count = 0;
    int          num_checks = 0;
    logic [1:0]  r;
    logic [31:0] d;

    always #5 clk_i = ~clk_i;

    rps_top #(.NUM_FUNC(64)) rps_top_i (
        .clk_i(clk_i), .rst_i(rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .periph_out_i(periph), .pin_data_o(pin_data), .pin_remap_o(pin_remap)
    );

    // One comparison, four-state exact
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Write: AW and W offered together, each released once taken
    task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        int   n;
        logic at, wt, bt;
        @(posedge clk_i);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        n = 0;
        do begin
            // Mid-cycle sample equals what the next rising edge sees
            @(negedge clk_i);
            at = awvalid && awready;
            wt = wvalid && wready;
            bt = bvalid;
            rs = bresp;
            n++;
            @(posedge clk_i);
            if (at) awvalid <= 1'b0;
            if (wt) wvalid <= 1'b0;
        end while (!bt);
        // Take edge, commit edge, then the answer is seen
        chk(n, 32'd3, "write answer latency");
    endtask

    // Read: AR held until taken, data taken with rvalid
    task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        int   n;
        logic at, rt;
        @(posedge clk_i);
        araddr  <= a;
        arvalid <= 1'b1;
        n = 0;
        do begin
            @(negedge clk_i);
            at = arvalid && arready;
            rt = rvalid;
            v  = rdata;
            rs = rresp;
            n++;
            @(posedge clk_i);
            if (at) arvalid <= 1'b0;
        end while (!rt);
        // Answer stands right after the address is taken
        chk(n, 32'd2, "read answer latency");
    endtask

    // Drive a peripheral pattern and compare all four pins to the model
    task automatic check_pins(input logic [63:0] p);
        logic [3:0] er, ed;
        @(posedge clk_i);
        periph <= p;
        // Register update plus one pin stage, with margin
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        for (int k = 0; k < 4; k++) begin
            er[k] = (sel_m[k] != RPS_SEL_NONE);
            ed[k] = er[k] & p[sel_m[k]];
        end
        chk({28'h0, pin_remap}, {28'h0, er}, "pin owner");
        chk({28'h0, pin_data}, {28'h0, ed}, "pin level");
    endtask

    // Program one register with the spare bits set, read back, route
    task automatic wr_pair(input logic [3:0] a, input int i, input logic [5:0] lo,
                           input logic [5:0] hi);
        axw(a, {16'hffff, 2'b11, hi, 2'b11, lo}, r);
        chk({30'h0, r}, {30'h0, RPS_RESP_OKAY}, "write resp");
        sel_m[i]     = lo;
        sel_m[i + 1] = hi;
        axr(a, d, r);
        chk(d, {18'h0, hi, 2'b00, lo}, "readback");
        check_pins(64'h1 << lo);
        check_pins(~(64'h1 << hi));
    endtask

    // Unmapped word: error answer, nothing stored
    task automatic unmapped();
        axw(4'h8, 32'h0000_3f3f, r);
        chk({30'h0, r}, {30'h0, RPS_RESP_SLVERR}, "bad write resp");
        axr(4'h8, d, r);
        chk({30'h0, r}, {30'h0, RPS_RESP_SLVERR}, "bad read resp");
        chk(d, 32'h0, "bad read data");
        check_pins(64'hffff_ffff_ffff_ffff);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog: whole run needs only about a hundred cycles
    initial begin
        #200us;
        err_count++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        axr(RPS_OFS_PAIR_A, d, r);
        chk(d, 32'h0, "reset pair a");
        axr(RPS_OFS_PAIR_B, d, r);
        chk(d, 32'h0, "reset pair b");
        check_pins(64'hffff_ffff_ffff_ffff);
        wr_pair(RPS_OFS_PAIR_A, 0, 6'h01, 6'h3e);
        wr_pair(RPS_OFS_PAIR_B, 2, 6'h21, 6'h3f);
        wr_pair(RPS_OFS_PAIR_A, 0, 6'h00, 6'h07);
        wr_pair(RPS_OFS_PAIR_B, 2, 6'h3f, 6'h00);
        unmapped();
        axr(RPS_OFS_PAIR_A, d, r);
        chk(d, 32'h0000_0700, "pair a kept");
        summarize();
    end
endmodule
`default_nettype wire
